/* rtl/lc_pkg.sv */
// package of constants and carrier types for the logic cluster
package lc_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int LC_ELEMS = 8;
    localparam int LC_ROWS = 6;
    localparam int LC_LINES = 3;
    localparam int LC_LINE_W = 4;
    localparam int LC_LUT_W = 64;
    localparam int LC_ECFG_W = 17;
    localparam logic [3:0] LC_MAX_CTL = 4'hb;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] LC_CTRL_OFS = 8'h00;
    localparam logic [7:0] LC_STAT_OFS = 8'h04;
    localparam logic [3:0] LC_ELEM_FIRST = 4'h1;
    localparam logic [3:0] LC_ELEM_LAST = 4'h8;
    localparam logic [1:0] LC_LUT_LO_SEL = 2'h0;
    localparam logic [1:0] LC_LUT_HI_SEL = 2'h1;
    localparam logic [1:0] LC_ECFG_SEL = 2'h2;

    // ****************************************
    // control word fields and reset values
    // ****************************************
    localparam int LC_SRC_W = 3;
    localparam int LC_FALL_POS = 3;
    localparam int LC_AL_BIT = 12;
    localparam int LC_SCLR_BIT = 13;
    localparam int LC_SLOAD_BIT = 14;
    localparam int LC_ACLR_LSB = 15;
    localparam logic [31:0] LC_CTRL_MASK = 32'h0001_ffff;
    localparam logic [31:0] LC_CTRL_RST = 32'h0000_0000;

    // status word fields
    localparam int LC_ST_CNT_LSB = 0;
    localparam int LC_ST_DIST_LSB = 4;
    localparam int LC_ST_CONF_BIT = 6;
    localparam int LC_ST_USED_LSB = 8;
    localparam int LC_ST_Q_LSB = 16;

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic aload_f;
        logic pack;
        logic chain;
        logic aclr_sel;
        logic feedback;
        logic reg_local;
        logic [1:0] line;
    } lc_regcfg_t;

    typedef struct packed {
        logic sixin;
        lc_regcfg_t [1:0] rc;
    } lc_ecfg_t;

    typedef struct packed {
        logic [2:0] ena;
        logic [1:0] aclr;
        logic sclr;
        logic aload;
        logic sload;
    } lc_ctl_t;

    typedef struct packed {
        logic [2:0] tick;
        logic [1:0] aclr;
        logic sclr;
        logic aload;
        logic sload;
    } lc_line_t;
endpackage

/* rtl/lc_element.sv */
// one logic element: two lookup halves, two registers and output sets
`timescale 1ns/1ps
module lc_element
    import lc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [LC_LUT_W-1:0] lut,
    input wire lc_ecfg_t cfg,
    input wire lc_line_t ctl,
    input wire logic [7:0] data,
    input wire logic chain_in,
    output logic chain_out,
    output logic [1:0] reg_q,
    output logic [1:0] route_out,
    output logic [1:0] local_out
);
    typedef struct packed {
        logic [1:0] q;
        logic [1:0] route;
        logic [1:0] loc;
    } lc_elem_st_t;

    lc_elem_st_t s;
    lc_elem_st_t next_s;
    logic [1:0] res;
    logic [1:0] adata;

    // ****************************************
    // lookup halves and register next state
    // ****************************************
    // data bits: 0..3 shared a..d, 4/5 upper pair of set 0, 6/7 of set 1
    always_comb begin
        logic [4:0] idx0;
        logic [4:0] idx1;
        logic h0;
        logic h1;
        logic dn;
        logic tk;
        logic [1:0] ln;
        idx0 = '0;
        idx1 = '0;
        h0 = 1'b0;
        h1 = 1'b0;
        dn = 1'b0;
        tk = 1'b0;
        ln = '0;
        next_s = s;
        // feedback replaces the d input with the register's own output
        idx0 = {data[4], cfg.rc[0].feedback ? s.q[0] : data[3], data[2:0]};
        idx1 = {cfg.sixin ? data[4] : data[6], cfg.rc[1].feedback ? s.q[1] : data[3], data[2:0]};
        h0 = lut[{1'b0, idx0}];
        h1 = lut[{1'b1, idx1}];
        // six-input mode: upper input of set 0 picks between the halves
        res[0] = cfg.sixin ? (data[5] ? h1 : h0) : h0;
        res[1] = h1;
        for (int r = 0; r < 2; r++) begin
            adata[r] = cfg.rc[r].aload_f ? data[5 + 2 * r] : data[4 + 2 * r];
            ln = cfg.rc[r].line;
            tk = (ln != 2'h3) && ctl.tick[ln];
            if (cfg.rc[r].chain) begin
                dn = (r == 0) ? chain_in : s.q[0];
            end else if (cfg.rc[r].pack) begin
                dn = data[4 + 2 * r];
            end else begin
                dn = res[r];
            end
            // clear outranks load so a glitching pair settles at zero
            if (ctl.aclr[cfg.rc[r].aclr_sel]) begin
                next_s.q[r] = 1'b0;
            end else if (ctl.aload) begin
                next_s.q[r] = adata[r];
            end else if (tk) begin
                if (ctl.sclr) begin
                    next_s.q[r] = 1'b0;
                end else if (ctl.sload) begin
                    next_s.q[r] = adata[r];
                end else begin
                    next_s.q[r] = dn;
                end
            end
            // one output of the set carries the register, the other the lookup
            next_s.loc[r] = cfg.rc[r].reg_local ? s.q[r] : res[r];
            next_s.route[r] = cfg.rc[r].reg_local ? res[r] : s.q[r];
        end
    end

    // state register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign reg_q = s.q;
    assign chain_out = s.q[1];
    assign route_out = s.route;
    assign local_out = s.loc;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_aclr_wins;
        ctl.aclr[cfg.rc[0].aclr_sel] && ctl.aload |=> !reg_q[0];
    endproperty
    a_aclr_wins: assert property (p_aclr_wins) else $error("clear lost to load");

    property p_preset;
        ctl.aload && !ctl.aclr[cfg.rc[1].aclr_sel] && adata[1] |=> reg_q[1];
    endproperty
    a_preset: assert property (p_preset) else $error("load high did not preset");

    property p_chain;
        cfg.rc[1].chain && cfg.rc[1].line != 2'h3 && ctl.tick[cfg.rc[1].line]
            && !(|ctl.aclr) && !ctl.aload && !ctl.sclr && !ctl.sload |=> reg_q[1] == $past(reg_q[0]);
    endproperty
    a_chain: assert property (p_chain) else $error("chain did not shift");

    property p_both_out;
        !cfg.rc[0].reg_local ##1 !$past(cfg.rc[0].reg_local) |-> route_out[0] == $past(reg_q[0])
            && local_out[0] == $past(res[0]);
    endproperty
    a_both_out: assert property (p_both_out) else $error("output set mismatch");
endmodule

/* rtl/lc_logic_cluster.sv */
// logic cluster: control generation, configuration slave, eight elements
// ****************************************
// Behaviour
// - cluster holds eight elements with shared routing, chains and controls.
// - controls: three clocks, three enables, two clears, sclr, aload, sload; eleven max.
// - at most two distinct row sources feed the three cluster clock lines.
// - every clock line travels with its own clock enable.
// - rising and falling use of one source takes two clock lines.
// - an inactive enable gates its line; registers on it hold.
// - asynchronous load with data high acts as a preset to one.
// - using asynchronous load takes enable zero away from other use.
// - controls come from row clocks five down to zero plus local routing.
// - each register has data, clock, enable, clears, loads and load data.
// - asynchronous load data comes from one of the two upper inputs.
// - combinational use bypasses the register to the outputs.
// - lookup drives one output while the register drives the other.
// - register output can feed back into its own lookup.
// - registered and unregistered results can leave at once.
// - two outputs per set; one of them also reaches local routing.
// - two lookup halves on eight inputs make any six-input function.
// - a chain path carries each register to its neighbour register.
// ****************************************
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module lc_logic_cluster
    import lc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [LC_ROWS-1:0] row_clk,
    input wire lc_ctl_t route_ctl,
    input wire logic [LC_ELEMS*8-1:0] elem_data,
    output logic [LC_ELEMS*2-1:0] route_out,
    output logic [LC_ELEMS*2-1:0] local_out
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [LC_ROWS-1:0] rs1;
        logic [LC_ROWS-1:0] rs2;
        logic [LC_ROWS-1:0] rprev;
        logic [31:0] ctrl;
        logic [LC_ELEMS-1:0][LC_LUT_W-1:0] lut;
        lc_ecfg_t [LC_ELEMS-1:0] ecfg;
        logic ack;
        logic [31:0] rdata;
    } lc_clu_st_t;

    lc_clu_st_t s;
    lc_clu_st_t next_s;

    logic req;
    logic [LC_ROWS-1:0] rise;
    logic [LC_ROWS-1:0] fall;
    logic [2:0] raw_tick;
    logic [2:0] used;
    logic [2:0] used_ok;
    logic [2:0] ena_eff;
    logic same01;
    logic same02;
    logic same12;
    logic [1:0] distinct;
    logic conflict;
    logic [3:0] ctl_cnt;
    lc_line_t lines;
    logic [LC_ELEMS*2-1:0] qv;
    logic [LC_ELEMS-1:0] chain;
    logic [31:0] stat;

    // byte-lane merge for partial writes
    function automatic logic [31:0] lc_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                m[8 * b +: 8] = wd[8 * b +: 8];
            end
        end
        return m;
    endfunction

    // ****************************************
    // cluster control generation
    // ****************************************
    // row clocks are only sampled; an edge becomes a one-cycle tick
    always_comb begin
        logic [2:0] src;
        src = '0;
        rise = s.rs2 & ~s.rprev;
        fall = ~s.rs2 & s.rprev;
        for (int i = 0; i < LC_LINES; i++) begin
            src = s.ctrl[LC_LINE_W * i +: LC_SRC_W];
            if (src < 3'(LC_ROWS)) begin
                // a line's fall bit picks the falling edge of its source, otherwise the rising edge
                raw_tick[i] = s.ctrl[LC_LINE_W * i + LC_FALL_POS] ? fall[src] : rise[src];
            end else begin
                raw_tick[i] = 1'b0;
            end
        end
    end

    // which lines any register of the cluster listens to
    always_comb begin
        used = '0;
        for (int e = 0; e < LC_ELEMS; e++) begin
            for (int r = 0; r < 2; r++) begin
                if (s.ecfg[e].rc[r].line != 2'h3) begin
                    used[s.ecfg[e].rc[r].line] = 1'b1;
                end
            end
        end
    end

    // distinct sources; a third one is refused by silencing line two
    assign same01 = s.ctrl[0 +: LC_SRC_W] == s.ctrl[LC_LINE_W +: LC_SRC_W];
    assign same02 = s.ctrl[0 +: LC_SRC_W] == s.ctrl[2 * LC_LINE_W +: LC_SRC_W];
    assign same12 = s.ctrl[LC_LINE_W +: LC_SRC_W] == s.ctrl[2 * LC_LINE_W +: LC_SRC_W];
    assign distinct = 2'(used[0]) + 2'(used[1] & ~(used[0] & same01))
        + 2'(used[2] & ~(used[0] & same02) & ~(used[1] & same12));
    assign conflict = distinct == 2'h3;
    assign used_ok = used & {~conflict, 2'b11};

    // enable zero is pinned on once asynchronous load owns its routing
    always_comb begin
        ena_eff = route_ctl.ena;
        if (s.ctrl[LC_AL_BIT]) begin
            ena_eff[0] = 1'b1;
        end
    end

    // controls that are not switched on stay inactive
    always_comb begin
        lines.tick = raw_tick & ena_eff & used_ok;
        lines.aclr = route_ctl.aclr & s.ctrl[LC_ACLR_LSB +: 2];
        lines.sclr = route_ctl.sclr & s.ctrl[LC_SCLR_BIT];
        lines.aload = route_ctl.aload & s.ctrl[LC_AL_BIT];
        lines.sload = route_ctl.sload & s.ctrl[LC_SLOAD_BIT];
    end

    // live control count: a clock and its enable per line plus the rest
    assign ctl_cnt = 4'($countones(used_ok) * 2 + $countones(s.ctrl[LC_AL_BIT +: 5]));

    // status word
    always_comb begin
        stat = '0;
        stat[LC_ST_CNT_LSB +: 4] = ctl_cnt;
        stat[LC_ST_DIST_LSB +: 2] = distinct;
        stat[LC_ST_CONF_BIT] = conflict;
        stat[LC_ST_USED_LSB +: 3] = used_ok;
        stat[LC_ST_Q_LSB +: 16] = qv;
    end

    // ****************************************
    // bus slave and state update
    // ****************************************
    assign req = avs_read | avs_write;
    // one wait cycle on every access, whatever the address
    assign avs_waitrequest = req & ~s.ack;
    assign avs_readdata = s.rdata;

    always_comb begin
        logic [2:0] ei;
        logic hit_e;
        logic [31:0] rd;
        ei = 3'(avs_address[7:4] - LC_ELEM_FIRST);
        hit_e = avs_address[7:4] >= LC_ELEM_FIRST && avs_address[7:4] <= LC_ELEM_LAST
            && avs_address[1:0] == 2'h0;
        rd = '0;
        next_s = s;
        // pin synchronisers; only the second stage is looked at
        next_s.rs1 = row_clk;
        next_s.rs2 = s.rs1;
        next_s.rprev = s.rs2;
        next_s.ack = req & ~s.ack;
        // read data is caught at the first edge and stands while ack is up
        if (avs_read && !s.ack) begin
            if (avs_address == LC_CTRL_OFS) begin
                rd = s.ctrl;
            end else if (avs_address == LC_STAT_OFS) begin
                rd = stat;
            end else if (hit_e) begin
                case (avs_address[3:2])
                    LC_LUT_LO_SEL: rd = s.lut[ei][31:0];
                    LC_LUT_HI_SEL: rd = s.lut[ei][63:32];
                    LC_ECFG_SEL: rd = {15'h0000, s.ecfg[ei]};
                    default: rd = '0;
                endcase
            end
            next_s.rdata = rd;
        end
        // a write lands on the edge where waitrequest is low
        if (avs_write && s.ack) begin
            if (avs_address == LC_CTRL_OFS) begin
                next_s.ctrl = lc_merge(s.ctrl, avs_writedata, avs_byteenable) & LC_CTRL_MASK;
            end else if (hit_e) begin
                case (avs_address[3:2])
                    LC_LUT_LO_SEL: next_s.lut[ei][31:0] = lc_merge(s.lut[ei][31:0], avs_writedata, avs_byteenable);
                    LC_LUT_HI_SEL: next_s.lut[ei][63:32] = lc_merge(s.lut[ei][63:32], avs_writedata, avs_byteenable);
                    LC_ECFG_SEL: next_s.ecfg[ei] = LC_ECFG_W'(lc_merge({15'h0000, s.ecfg[ei]},
                        avs_writedata, avs_byteenable));
                    default: next_s.ecfg[ei] = s.ecfg[ei];
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.ctrl <= LC_CTRL_RST;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // the eight elements
    // ****************************************
    // element g chains from element g-1; the first has nothing upstream
    for (genvar g = 0; g < LC_ELEMS; g++) begin : g_elem
        lc_element u_elem (
            .mclk(mclk),
            .rst_n(rst_n),
            .lut(s.lut[g]),
            .cfg(s.ecfg[g]),
            .ctl(lines),
            .data(elem_data[8 * g +: 8]),
            .chain_in((g == 0) ? 1'b0 : chain[(g == 0) ? 0 : g - 1]),
            .chain_out(chain[g]),
            .reg_q(qv[2 * g +: 2]),
            .route_out(route_out[2 * g +: 2]),
            .local_out(local_out[2 * g +: 2])
        );
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_two_src;
        distinct == 2'h3 |-> !lines.tick[2] && conflict;
    endproperty
    a_two_src: assert property (p_two_src) else $error("third source got a tick");

    property p_ena_gate;
        !route_ctl.ena[1] |-> !lines.tick[1];
    endproperty
    a_ena_gate: assert property (p_ena_gate) else $error("disabled line ticked");

    property p_aload_ena0;
        s.ctrl[LC_AL_BIT] && raw_tick[0] && used_ok[0] |-> lines.tick[0];
    endproperty
    a_aload_ena0: assert property (p_aload_ena0) else $error("enable zero still gates");

    property p_ctl_limit;
        ctl_cnt <= LC_MAX_CTL && ctl_cnt >= 4'($countones(used_ok));
    endproperty
    a_ctl_limit: assert property (p_ctl_limit) else $error("control count out of range");

    property p_dual_edge;
        same01 && s.ctrl[LC_FALL_POS] != s.ctrl[LC_LINE_W + LC_FALL_POS] |-> !(raw_tick[0] && raw_tick[1]);
    endproperty
    a_dual_edge: assert property (p_dual_edge) else $error("both edges in one cycle");

    property p_row_src;
        s.ctrl[2:0] == 3'h0 && !s.ctrl[LC_FALL_POS] && raw_tick[0] |-> $past(row_clk[0], 2) && !$past(row_clk[0], 3);
    endproperty
    a_row_src: assert property (p_row_src) else $error("tick without row edge");

    property p_bus_answer;
        req && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("no answer after one wait");

    property p_ctrl_write;
        avs_write && !avs_waitrequest && avs_address == LC_CTRL_OFS && avs_byteenable == 4'hf
            |=> s.ctrl == ($past(avs_writedata) & LC_CTRL_MASK);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");
endmodule

/* verif/lc_logic_cluster_test.sv */
// self-checking bench for the logic cluster: bus, row clocks, async controls
`timescale 1ns/1ps
module lc_logic_cluster_test
    import lc_pkg::*;
;
    // ****************************************
    // signals
    // ****************************************
    logic mclk;
    logic rst_n;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [LC_ROWS-1:0] row_clk;
    lc_ctl_t route_ctl;
    logic [LC_ELEMS*8-1:0] elem_data;
    logic [LC_ELEMS*2-1:0] route_out;
    logic [LC_ELEMS*2-1:0] local_out;
    int n_fail;
    int tests_run;
    logic [31:0] rd;

    lc_logic_cluster DUT (
        .mclk(mclk),
        .rst_n(rst_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .row_clk(row_clk),
        .route_ctl(route_ctl),
        .elem_data(elem_data),
        .route_out(route_out),
        .local_out(local_out)
    );

    // 100 MHz system clock
    always #5 mclk = ~mclk;

    // ****************************************
    // shared tasks
    // ****************************************
    task end_sim;
        $display("counts: comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one avalon transfer; request held until waitrequest is sampled low at a rising edge
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            end_sim();
        end else begin
            // the write lands and the read data is taken at this same edge
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask

    // one rising pulse on a row clock, long enough for sync, tick and output stage
    task tick(input int r);
        @(posedge mclk);
        row_clk[r] <= 1'b1;
        repeat (6) @(posedge mclk);
        row_clk[r] <= 1'b0;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task test_reset;
        bus(1'b0, LC_CTRL_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        bus(1'b1, 8'hfc, 32'hffff_ffff);
        bus(1'b0, 8'hfc, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test_reset done");
    endtask

    // element 0: register on local, lookup on route; reg1 chained from reg0
    task test_route;
        bus(1'b1, LC_CTRL_OFS, 32'h0000_0770);
        bus(1'b1, 8'h10, 32'h0000_0002);
        bus(1'b1, 8'h18, 32'h0000_2404);
        repeat (4) @(negedge mclk);
        chk(32'(route_out[1:0]), 32'h0000_0001);
        chk(32'(local_out[1:0]), 32'h0000_0000);
        tick(0);
        chk(32'(local_out[1:0]), 32'h0000_0001);
        chk(32'(route_out[0]), 32'h0000_0001);
        bus(1'b0, LC_STAT_OFS, 32'h0000_0000);
        chk(rd, 32'h0001_0112);
        $display("test_route done");
    endtask

    // enable low must freeze the line; data change shows only on the lookup path
    task test_enable;
        @(posedge mclk);
        route_ctl.ena[0] <= 1'b0;
        elem_data <= 64'h0000_0000_0000_0000;
        tick(0);
        chk(32'(local_out[1:0]), 32'h0000_0001);
        chk(32'(route_out[0]), 32'h0000_0000);
        @(posedge mclk);
        route_ctl.ena[0] <= 1'b1;
        tick(0);
        chk(32'(local_out[1:0]), 32'h0000_0002);
        $display("test_enable done");
    endtask

    // preset through load data high, then clear held over it
    task test_async;
        bus(1'b1, LC_CTRL_OFS, 32'h0000_9770);
        @(posedge mclk);
        elem_data <= 64'h0000_0000_0000_0010;
        route_ctl.aload <= 1'b1;
        repeat (4) @(negedge mclk);
        chk(32'(local_out[0]), 32'h0000_0001);
        @(posedge mclk);
        route_ctl.aclr[0] <= 1'b1;
        repeat (4) @(negedge mclk);
        chk(32'(local_out[0]), 32'h0000_0000);
        @(posedge mclk);
        route_ctl.aclr[0] <= 1'b0;
        repeat (4) @(negedge mclk);
        chk(32'(local_out[0]), 32'h0000_0001);
        @(posedge mclk);
        route_ctl.aload <= 1'b0;
        $display("test_async done");
    endtask

    // three distinct sources: the third line is silenced, the second still works
    task test_conflict;
        bus(1'b1, LC_CTRL_OFS, 32'h0000_0210);
        bus(1'b1, 8'h20, 32'hffff_ffff);
        bus(1'b1, 8'h24, 32'hffff_ffff);
        bus(1'b1, 8'h28, 32'h0000_0506);
        bus(1'b0, LC_STAT_OFS, 32'h0000_0000);
        chk(32'(rd[6]), 32'h0000_0001);
        tick(2);
        chk(32'(local_out[3:2]), 32'h0000_0000);
        chk(32'(route_out[3:2]), 32'h0000_0003);
        tick(1);
        chk(32'(local_out[3:2]), 32'h0000_0002);
        $display("test_conflict done");
    endtask

    // one source on both edges: rising line toggles through feedback, falling line chains it
    task test_modes;
        bus(1'b1, LC_CTRL_OFS, 32'h0000_67b3);
        bus(1'b1, 8'h30, 32'h0000_0001);
        bus(1'b1, 8'h38, 32'h0000_250c);
        bus(1'b0, 8'h38, 32'h0000_0000);
        chk(rd, 32'h0000_250c);
        bus(1'b0, LC_STAT_OFS, 32'h0000_0000);
        chk(rd, 32'h0009_0728);
        tick(3);
        chk(32'(local_out[5:4]), 32'h0000_0003);
        tick(3);
        chk(32'(local_out[5:4]), 32'h0000_0000);
        @(posedge mclk);
        route_ctl.ena[1] <= 1'b0;
        tick(3);
        chk(32'(local_out[5:4]), 32'h0000_0001);
        @(posedge mclk);
        route_ctl.ena[1] <= 1'b1;
        route_ctl.sload <= 1'b1;
        elem_data <= 64'h0000_0000_0010_0000;
        tick(3);
        chk(32'(local_out[5:4]), 32'h0000_0001);
        @(posedge mclk);
        route_ctl.sclr <= 1'b1;
        tick(3);
        chk(32'(local_out[5:4]), 32'h0000_0000);
        @(posedge mclk);
        route_ctl.sclr <= 1'b0;
        route_ctl.sload <= 1'b0;
        $display("test_modes done");
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
        row_clk = '0;
        route_ctl = '0;
        route_ctl.ena = 3'b111;
        elem_data = 64'h0000_0000_0000_0001;
        n_fail = 0;
        tests_run = 0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        test_reset();
        test_route();
        test_enable();
        test_async();
        test_conflict();
        test_modes();
        end_sim();
    end
endmodule
